// >>> pkg/reset_init_regs.svh
`ifndef RESET_INIT_REGS_SVH
`define RESET_INIT_REGS_SVH
`define CLK_SYS_MHZ 50
`define MIN_ASSERT_TICKS 32
`define RST_OUT_TICKS 512
`define HARD_TO_SOFT_TICKS 16
`define CFG_SETUP_CLKS 4
`define CFG_ON_TICKS 4
`define CFG_ON_MIN_TICKS 1
`define PLL_LOCK_US 100
`define PLL_LOCK_CYCLES (`PLL_LOCK_US * `CLK_SYS_MHZ)
`define DLL_LOCK_MIN 7680
`define DLL_LOCK_MAX 122880
`define CNT_W 17
`define TICK_MAX_DIV 2
`define LO_CNT_W 6
`define BRD_CNT_W 7
`endif

// >>> pkg/reset_init_pkg.sv
package reset_init_pkg;
  typedef enum {S_POR, S_PLL, S_DLL, S_HOLD, S_GAP, S_SOFT, S_RUN} seq_state_t;
  typedef enum {B_POR, B_CFG_HOLD, B_HARD, B_SOFT, B_IDLE} brd_state_t;
  typedef logic [2:0] reset_src_t;
endpackage

// >>> pkg/reset_init_if.sv
`timescale 1ns/1ps
interface reset_init_if;
  logic power_on_reset_n;
  logic host_mode;
  logic hard_dev_o;
  logic hard_dev_oe_n;
  logic hard_brd_oe_n;
  logic soft_dev_o;
  logic soft_dev_oe_n;
  logic soft_brd_oe_n;
  logic hard_reset_n;
  logic soft_reset_n;
  logic [2:0] cfg_src_dev;
  logic [2:0] cfg_src_brd;
  logic [2:0] cfg_src;
  logic cfg_div_dev;
  logic cfg_div_brd;
  logic cfg_div;
  logic cfg_dev_oe_n;
  logic cfg_brd_oe_n;
  // Open-drain lines with a pull-up: low whenever either end drives.
  assign hard_reset_n = (hard_dev_oe_n | hard_dev_o) & hard_brd_oe_n;
  assign soft_reset_n = (soft_dev_oe_n | soft_dev_o) & soft_brd_oe_n;
  assign cfg_src = !cfg_dev_oe_n ? cfg_src_dev : (!cfg_brd_oe_n ? cfg_src_brd : 3'h0);
  assign cfg_div = !cfg_dev_oe_n ? cfg_div_dev : (!cfg_brd_oe_n ? cfg_div_brd : 1'h0);
  modport device (
    input power_on_reset_n, host_mode, hard_reset_n, soft_reset_n, cfg_src, cfg_div,
    output hard_dev_o, hard_dev_oe_n, soft_dev_o, soft_dev_oe_n, cfg_src_dev, cfg_div_dev, cfg_dev_oe_n
  );
  modport board (
    input hard_reset_n, soft_reset_n, cfg_src, cfg_div,
    output power_on_reset_n, host_mode, hard_brd_oe_n, soft_brd_oe_n, cfg_src_brd, cfg_div_brd, cfg_brd_oe_n
  );
endinterface

// >>> rtl/reset_init_board.sv
`timescale 1ns/1ps
`include "reset_init_regs.svh"
module reset_init_board import reset_init_pkg::*; #(
  parameter int HOLD_CYCLES = `MIN_ASSERT_TICKS * `TICK_MAX_DIV
) (
  input logic clk_sys, // System clock.
  input logic rst, // Synchronous reset, active high.
  reset_init_if.board pins, // Link to the device.
  input logic por_req, // Pulse: run a power-on reset.
  input logic hard_req, // Pulse: request a hard reset.
  input logic soft_req, // Pulse: request a soft reset.
  input logic host_mode_sel, // Strap level: 1 host, 0 agent.
  input reset_src_t cfg_src_val, // Reset-source selector to strap.
  input logic cfg_div_val, // Clock-divide select to strap.
  output logic busy // High while a reset is being applied.
);
  generate
    if (HOLD_CYCLES < `MIN_ASSERT_TICKS * `TICK_MAX_DIV || HOLD_CYCLES >= 2 ** `BRD_CNT_W) begin : g_chk
      $error("HOLD_CYCLES out of range");
    end
  endgenerate

  brd_state_t st_r, st_nxt;
  logic [`BRD_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] hsync_r;
  logic por_n_r, por_n_nxt, hard_oe_n_r, hard_oe_n_nxt, soft_oe_n_r, soft_oe_n_nxt;
  logic cfg_oe_n_r, cfg_oe_n_nxt, host_r, div_r, busy_r;
  reset_src_t src_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 1'b1;
    por_n_nxt = por_n_r;
    hard_oe_n_nxt = hard_oe_n_r;
    soft_oe_n_nxt = soft_oe_n_r;
    cfg_oe_n_nxt = cfg_oe_n_r;
    unique case (st_r)
      B_POR: begin
        // Straps are driven the whole time, well ahead of release.
        cfg_oe_n_nxt = 1'b0;
        if (cnt_r == `BRD_CNT_W'(HOLD_CYCLES - 1)) begin
          por_n_nxt = 1'b1;
          st_nxt = B_CFG_HOLD;
        end
      end
      B_CFG_HOLD: begin
        if (hsync_r[1]) begin
          cfg_oe_n_nxt = 1'b1;
          st_nxt = B_IDLE;
        end
      end
      B_HARD, B_SOFT: begin
        if (cnt_r == `BRD_CNT_W'(HOLD_CYCLES - 1)) begin
          hard_oe_n_nxt = 1'b1;
          soft_oe_n_nxt = 1'b1;
          st_nxt = B_IDLE;
        end
      end
      B_IDLE: begin
        cnt_nxt = '0;
        if (por_req) begin
          por_n_nxt = 1'b0;
          cfg_oe_n_nxt = 1'b0;
          st_nxt = B_POR;
        end else if (hard_req) begin
          hard_oe_n_nxt = 1'b0;
          st_nxt = B_HARD;
        end else if (soft_req) begin
          soft_oe_n_nxt = 1'b0;
          st_nxt = B_SOFT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= B_POR;
      cnt_r <= '0;
      hsync_r <= 2'h0;
      por_n_r <= 1'b0;
      hard_oe_n_r <= 1'b1;
      soft_oe_n_r <= 1'b1;
      cfg_oe_n_r <= 1'b0;
      host_r <= 1'b0;
      div_r <= 1'b0;
      src_r <= 3'h0;
      busy_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      hsync_r <= {hsync_r[0], pins.hard_reset_n};
      por_n_r <= por_n_nxt;
      hard_oe_n_r <= hard_oe_n_nxt;
      soft_oe_n_r <= soft_oe_n_nxt;
      cfg_oe_n_r <= cfg_oe_n_nxt;
      host_r <= host_mode_sel;
      div_r <= cfg_div_val;
      src_r <= cfg_src_val;
      busy_r <= st_nxt != B_IDLE;
    end
  end

  assign pins.power_on_reset_n = por_n_r;
  assign pins.host_mode = host_r;
  assign pins.hard_brd_oe_n = hard_oe_n_r;
  assign pins.soft_brd_oe_n = soft_oe_n_r;
  assign pins.cfg_src_brd = src_r;
  assign pins.cfg_div_brd = div_r;
  assign pins.cfg_brd_oe_n = cfg_oe_n_r;
  assign busy = busy_r;
endmodule

// >>> rtl/reset_init_device.sv
// Notes on behaviour
// - Board holds hard/soft input 32 sync periods.
// - Host mode: power-on reset 32 primary clocks.
// - Agent mode: power-on reset 32 sync clocks.
// - Hard and soft outputs asserted 512 periods.
// - Soft releases 16 periods after hard.
// - Straps valid 4 clocks before power-on release.
// - Straps held until hard reset releases.
// - Stop driving straps when hard asserts.
// - Drive straps again one period after release; the code waits 4 periods.
// - Host uses primary input, agent bus clock.
// - Host sync period set by divide strap.
// - Sample 3-bit source plus divide bit.
// - Wait up to 100 us PLL lock.
// - DLL wait 7680 to 122880 bus cycles.
`timescale 1ns/1ps
`include "reset_init_regs.svh"
module reset_init_device import reset_init_pkg::*; #(
  parameter int PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES,
  parameter int DLL_LOCK_CYCLES = `DLL_LOCK_MIN
) (
  input logic clk_sys, // System clock.
  input logic rst, // Synchronous reset, active high.
  reset_init_if.device pins, // Link to the board.
  input reset_src_t run_cfg_src, // Value driven on the source pins after reset.
  input logic run_cfg_div, // Value driven on the divide pin after reset.
  output reset_src_t reset_source_sel, // Source selector caught at power-on.
  output logic input_clock_divide_sel, // Divide select caught at power-on.
  output logic clock_from_bus, // 1 agent: bus clock input is primary.
  output logic sys_ready // High once soft reset is released.
);
  generate
    if (DLL_LOCK_CYCLES < `DLL_LOCK_MIN || DLL_LOCK_CYCLES > `DLL_LOCK_MAX) begin : g_dll_chk
      $error("DLL_LOCK_CYCLES out of range");
    end
    if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= 2 ** `CNT_W) begin : g_pll_chk
      $error("PLL_LOCK_CYCLES out of range");
    end
  endgenerate

  seq_state_t st_r, st_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`LO_CNT_W-1:0] lo_r, lo_nxt;
  logic [7:0] sync1_r, sync2_r;
  logic por_s, hard_s, soft_s, host_s, div_s;
  reset_src_t src_s;
  logic phase_r, tick;
  logic hard_oe_n_r, hard_oe_n_nxt, soft_oe_n_r, soft_oe_n_nxt, cfg_oe_n_r, cfg_oe_n_nxt;
  logic host_r, host_nxt, div_r, div_nxt, bus_clk_r, ready_r, ready_nxt;
  reset_src_t src_r, src_nxt, out_src_r;
  logic out_div_r;

  assign {por_s, hard_s, soft_s, host_s, div_s, src_s} = sync2_r;

  // Host mode with the divide strap set halves the sync rate; agent runs the bus clock direct.
  assign tick = !(host_r && div_r) || phase_r;

  function automatic logic done(input logic [`CNT_W-1:0] c, input int n);
    done = c == `CNT_W'(n - 1);
  endfunction

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    lo_nxt = lo_r;
    hard_oe_n_nxt = hard_oe_n_r;
    soft_oe_n_nxt = soft_oe_n_r;
    cfg_oe_n_nxt = cfg_oe_n_r;
    src_nxt = src_r;
    div_nxt = div_r;
    host_nxt = host_r;
    ready_nxt = ready_r;
    if (!por_s) begin
      // Board holds power-on reset for its required length; we just stay in reset.
      st_nxt = S_POR;
      cnt_nxt = '0;
      lo_nxt = '0;
      hard_oe_n_nxt = 1'b0;
      soft_oe_n_nxt = 1'b0;
      cfg_oe_n_nxt = 1'b1;
      ready_nxt = 1'b0;
    end else begin
      unique case (st_r)
        S_POR: begin
          // Straps are already stable at the synchronised release edge.
          src_nxt = src_s;
          div_nxt = div_s;
          host_nxt = host_s;
          cnt_nxt = '0;
          st_nxt = S_PLL;
        end
        S_PLL: begin
          cnt_nxt = cnt_r + 1'b1;
          if (done(cnt_r, PLL_LOCK_CYCLES)) begin
            cnt_nxt = '0;
            st_nxt = S_DLL;
          end
        end
        S_DLL: begin
          cnt_nxt = cnt_r + 1'b1;
          if (done(cnt_r, DLL_LOCK_CYCLES)) begin
            cnt_nxt = '0;
            st_nxt = S_HOLD;
          end
        end
        S_HOLD: begin
          if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
            if (done(cnt_r, `RST_OUT_TICKS)) begin
              cnt_nxt = '0;
              hard_oe_n_nxt = 1'b1;
              st_nxt = S_GAP;
            end
          end
        end
        S_GAP: begin
          if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
            if (done(cnt_r, `CFG_ON_TICKS)) begin
              cfg_oe_n_nxt = 1'b0;
            end
            if (done(cnt_r, `HARD_TO_SOFT_TICKS)) begin
              cnt_nxt = '0;
              soft_oe_n_nxt = 1'b1;
              ready_nxt = 1'b1;
              st_nxt = S_RUN;
            end
          end
        end
        S_SOFT: begin
          if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
            if (done(cnt_r, `RST_OUT_TICKS)) begin
              cnt_nxt = '0;
              soft_oe_n_nxt = 1'b1;
              ready_nxt = 1'b1;
              st_nxt = S_RUN;
            end
          end
        end
        S_RUN: begin
          if (tick) begin
            if (hard_s && soft_s) begin
              lo_nxt = '0;
            end else if (lo_r == `LO_CNT_W'(`MIN_ASSERT_TICKS - 1)) begin
              lo_nxt = '0;
              cnt_nxt = '0;
              soft_oe_n_nxt = 1'b0;
              ready_nxt = 1'b0;
              if (!hard_s) begin
                hard_oe_n_nxt = 1'b0;
                cfg_oe_n_nxt = 1'b1;
                st_nxt = S_HOLD;
              end else begin
                st_nxt = S_SOFT;
              end
            end else begin
              lo_nxt = lo_r + 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= S_POR;
      cnt_r <= '0;
      lo_r <= '0;
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      phase_r <= 1'b0;
      hard_oe_n_r <= 1'b0;
      soft_oe_n_r <= 1'b0;
      cfg_oe_n_r <= 1'b1;
      src_r <= 3'h0;
      div_r <= 1'b0;
      host_r <= 1'b0;
      bus_clk_r <= 1'b1;
      ready_r <= 1'b0;
      out_src_r <= 3'h0;
      out_div_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lo_r <= lo_nxt;
      sync1_r <= {pins.power_on_reset_n, pins.hard_reset_n, pins.soft_reset_n, pins.host_mode,
                  pins.cfg_div, pins.cfg_src};
      sync2_r <= sync1_r;
      phase_r <= ~phase_r;
      hard_oe_n_r <= hard_oe_n_nxt;
      soft_oe_n_r <= soft_oe_n_nxt;
      cfg_oe_n_r <= cfg_oe_n_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      host_r <= host_nxt;
      bus_clk_r <= ~host_nxt;
      ready_r <= ready_nxt;
      out_src_r <= run_cfg_src;
      out_div_r <= run_cfg_div;
    end
  end

  assign pins.hard_dev_o = 1'b0;
  assign pins.soft_dev_o = 1'b0;
  assign pins.hard_dev_oe_n = hard_oe_n_r;
  assign pins.soft_dev_oe_n = soft_oe_n_r;
  assign pins.cfg_dev_oe_n = cfg_oe_n_r;
  assign pins.cfg_src_dev = out_src_r;
  assign pins.cfg_div_dev = out_div_r;
  assign reset_source_sel = src_r;
  assign input_clock_divide_sel = div_r;
  assign clock_from_bus = bus_clk_r;
  assign sys_ready = ready_r;
endmodule

// >>> tb/reset_init_props.sv
`timescale 1ns/1ps
module reset_init_props (
  input logic clk_sys, // Clock.
  input logic rst, // Reset.
  input logic power_on_reset_n, // Power-on line.
  input logic hard_dev_oe_n, // Device hard drive.
  input logic soft_dev_oe_n, // Device soft drive.
  input logic hard_brd_oe_n, // Board hard drive.
  input logic hard_reset_n, // Hard line.
  input logic [2:0] cfg_src, // Strap value.
  input logic cfg_dev_oe_n, // Device strap drive.
  input logic cfg_brd_oe_n // Board strap drive.
);
  logic [15:0] lo_h_r, lo_s_r, hi_h_r, lo_b_r, lo_p_r;
  logic por_r;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Run lengths of each line state; the high count saturates.
  always_ff @(posedge clk_sys) begin
    lo_h_r <= (rst || hard_dev_oe_n) ? 16'h0 : lo_h_r + 16'h1;
    lo_s_r <= (rst || soft_dev_oe_n) ? 16'h0 : lo_s_r + 16'h1;
    lo_b_r <= (rst || hard_brd_oe_n) ? 16'h0 : lo_b_r + 16'h1;
    lo_p_r <= (rst || power_on_reset_n) ? 16'h0 : lo_p_r + 16'h1;
    hi_h_r <= (rst || !hard_dev_oe_n) ? 16'h0 : hi_h_r + {15'h0, ~&hi_h_r};
    por_r <= rst || !power_on_reset_n || (por_r && cfg_dev_oe_n);
  end
  sequence s_hard_up;
    $rose(hard_reset_n) && por_r;
  endsequence
  sequence s_soft_up;
    $rose(soft_dev_oe_n);
  endsequence
  property p_hard_len;
    $rose(hard_dev_oe_n) |-> lo_h_r >= 16'h200;
  endproperty
  property p_soft_len;
    s_soft_up |-> lo_s_r >= 16'h200;
  endproperty
  property p_gap;
    s_soft_up |-> hard_dev_oe_n && hi_h_r >= 16'h10;
  endproperty
  property p_float;
    !hard_dev_oe_n |-> cfg_dev_oe_n;
  endproperty
  property p_turn_on;
    $fell(cfg_dev_oe_n) |-> hard_reset_n && hi_h_r >= 16'h1;
  endproperty
  property p_lock;
    $rose(hard_dev_oe_n) && por_r |-> lo_h_r >= 16'h2000;
  endproperty
  property p_qual;
    $fell(hard_dev_oe_n) |-> lo_b_r >= 16'h20 || lo_p_r != 16'h0;
  endproperty
  property p_brd_len;
    $rose(hard_brd_oe_n) |-> lo_b_r >= 16'h20;
  endproperty
  property p_por_len;
    $rose(power_on_reset_n) |-> lo_p_r >= 16'h20;
  endproperty
  property p_setup;
    $rose(power_on_reset_n) |-> !$past(cfg_brd_oe_n, 4) && $past(cfg_src, 4) == cfg_src;
  endproperty
  property p_hold;
    s_hard_up |-> !cfg_brd_oe_n && $stable(cfg_src);
  endproperty
  a_hard_len: assert property (p_hard_len)
    else $error("hard output released early");
  a_soft_len: assert property (p_soft_len)
    else $error("soft output released early");
  a_gap: assert property (p_gap)
    else $error("soft released too soon after hard");
  a_float: assert property (p_float)
    else $error("straps driven during hard reset");
  a_turn_on: assert property (p_turn_on)
    else $error("straps driven too soon");
  a_lock: assert property (p_lock)
    else $error("lock wait too short");
  a_qual: assert property (p_qual)
    else $error("short input pulse accepted");
  a_por_len: assert property (p_por_len)
    else $error("power-on pulse too short");
  a_brd_len: assert property (p_brd_len)
    else $error("board hard pulse too short");
  a_setup: assert property (p_setup)
    else $error("straps not set up before release");
  a_hold: assert property (p_hold)
    else $error("straps not held to hard release");
endmodule

// >>> tb/test_reset_init_sequencer.sv
`timescale 1ns/1ps
module test_reset_init_sequencer import reset_init_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic por_req = 1'b0, hard_req = 1'b0, soft_req = 1'b0;
  logic host_mode_sel = 1'b0, cfg_div_val = 1'b1, run_cfg_div = 1'b1;
  reset_src_t cfg_src_val = 3'h5, run_cfg_src = 3'h6, reset_source_sel;
  logic input_clock_divide_sel, clock_from_bus, sys_ready, busy;
  int bad_count = 0, tests_run = 0, h, s;
  reset_init_if pins();
  always #10 clk_sys = ~clk_sys;
  reset_init_board i_reset_init_board (.clk_sys(clk_sys), .rst(rst), .pins(pins), .por_req(por_req),
    .hard_req(hard_req), .soft_req(soft_req), .host_mode_sel(host_mode_sel), .cfg_src_val(cfg_src_val),
    .cfg_div_val(cfg_div_val), .busy(busy));
  reset_init_device #(.PLL_LOCK_CYCLES(10)) i_reset_init_device (.clk_sys(clk_sys), .rst(rst),
    .pins(pins), .run_cfg_src(run_cfg_src), .run_cfg_div(run_cfg_div), .reset_source_sel(reset_source_sel),
    .input_clock_divide_sel(input_clock_divide_sel), .clock_from_bus(clock_from_bus), .sys_ready(sys_ready));
  reset_init_props i_props (.clk_sys(clk_sys), .rst(rst), .power_on_reset_n(pins.power_on_reset_n),
    .hard_dev_oe_n(pins.hard_dev_oe_n), .soft_dev_oe_n(pins.soft_dev_oe_n), .hard_brd_oe_n(pins.hard_brd_oe_n),
    .hard_reset_n(pins.hard_reset_n), .cfg_src(pins.cfg_src), .cfg_dev_oe_n(pins.cfg_dev_oe_n),
    .cfg_brd_oe_n(pins.cfg_brd_oe_n));
  task automatic check(input logic ok);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t unexpected value", $time);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic pulse(input int which);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    por_req = (which == 0);
    hard_req = (which == 1);
    soft_req = (which == 2);
    @(negedge clk_sys);
    por_req = 1'b0;
    hard_req = 1'b0;
    soft_req = 1'b0;
    check(busy === 1'b1);
  endtask
  // Counts cycles each device output pulls low until the system is ready again.
  task automatic run_seq();
    int n;
    h = 0;
    s = 0;
    n = 0;
    while (sys_ready === 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    // The current cycle is counted first, so a pull seen at this edge is not lost.
    while (sys_ready !== 1'b1 && n < 20000) begin
      h += (pins.hard_dev_oe_n === 1'b0);
      s += (pins.soft_dev_oe_n === 1'b0);
      @(negedge clk_sys);
      n++;
    end
    check(n < 20000);
  endtask
  task automatic t_power_on();
    run_seq();
    check(reset_source_sel === 3'h5);
    check(input_clock_divide_sel === 1'b1);
    check(clock_from_bus === 1'b1);
    check(h >= 512);
    check(s - h == 16);
    check(pins.cfg_src === 3'h6);
    check(pins.cfg_div === 1'b1);
  endtask
  task automatic t_hard();
    cfg_src_val = 3'h2;
    run_cfg_src = 3'h1;
    run_cfg_div = 1'b0;
    pulse(1);
    run_seq();
    check(reset_source_sel === 3'h5);
    check(h >= 512);
    check(s - h == 16);
    check(pins.cfg_src === 3'h1);
    check(pins.cfg_div === 1'b0);
  endtask
  task automatic t_soft();
    pulse(2);
    run_seq();
    check(h == 0);
    check(s >= 512);
  endtask
  task automatic t_host(input logic div);
    int t;
    t = div ? 2 : 1;
    host_mode_sel = 1'b1;
    cfg_div_val = div;
    cfg_src_val = 3'h3;
    pulse(0);
    run_seq();
    check(clock_from_bus === 1'b0);
    check(input_clock_divide_sel === div);
    check(reset_source_sel === 3'h3);
    check(h >= 512 * t);
    check(s - h == 16 * t);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    t_power_on();
    t_hard();
    t_soft();
    t_host(1'b1);
    t_host(1'b0);
    stop_test();
  end
  initial begin
    repeat (80000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end
endmodule
